/* core/pmic_status_config_regs.sv */
// I2C target and status/configuration register bank from offset 0x2E to 0x35.
// What this block does
// - Load-current register high returns count bit 8 in bit 0; 20 mA per count.
// - Load-current register low returns count bits 7 to 0, same scale.
// - Frequency bit 2 reads step-up frequency, 0 is 2 MHz, 1 is 4 MHz, OTP-loaded.
// - Frequency bits 1:0 set step-down frequency: 0 2 MHz, 1 3 MHz, else 4 MHz.
// - Two-bit step-up current limit: 1.0, 1.4, 1.9, 2.8 A, default from OTP.
// - Status bit 1 reads one after an uncorrected double OTP error.
// - Status bit 0 reads one after a corrected single OTP error.
// - Key writes 0x87, 0x65, 0x1B in a row clear the lock status.
// - The key sequence opens the lock only while watchdog lock is zero.
// - Any other key write, or watchdog lock written one, sets the lock again.
// - Reading the key register always returns zero.
// - Permit bit: one lets the disable pin stop the watchdog; OTP default.
// - Writing one to permit works only while both locks read zero.
// - Writing the select field picks the converter and starts a measurement.
`timescale 1ns/1ns
`include "pmic_regs_defs.svh"
module pmic_status_config_regs
	import pmic_regs_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h60 // Target address; arbitrary value.
) (
	input  wire logic          i_ref_clk,                 // 20 MHz system clock.
	input  wire logic          i_rst_n,                   // Synchronous reset, active low.
	input  wire logic          i_ce,                      // Clock enable; low freezes state.
	input  wire logic          i_scl,                     // Serial clock pin.
	input  wire logic          i_sda,                     // Serial data pin level.
	output logic               o_sda_o,                   // Serial data drive value.
	output logic               o_sda_oe,                  // Serial data pulled low when high.
	input  wire logic [8:0]    i_load_current,            // Averaged load-current count.
	input  wire logic          i_load_valid,              // Count is new this cycle.
	input  wire logic          i_otp_load,                // Load defaults from OTP.
	input  wire otp_defaults_s i_otp_defaults,            // OTP default values.
	input  wire logic          i_otp_single_err,          // Corrected single OTP error.
	input  wire logic          i_otp_double_err,          // Uncorrected double OTP error.
	input  wire logic          i_watchdog_config_lock,    // Watchdog configuration lock.
	input  wire logic          i_watchdog_lock_write_one, // Watchdog lock written to one.
	output logic               o_meas_start,              // Start a measurement, pulse.
	output logic               o_meas_sel,                // Zero first converter, one second.
	output logic [1:0]         o_step_down_frequency_choice, // Step-down frequency code.
	output logic               o_step_up_frequency_choice, // Step-up frequency code.
	output logic [1:0]         o_step_up_current_limit,   // Step-up current limit code.
	output logic               o_pin_disable_permit,      // Disable pin may stop watchdog.
	output logic               o_pin_disable_lock_status  // Permit bit locked.
);
	// ==========================================================
	// Pin synchronisation and bus conditions
	logic [1:0] pins_f;
	logic       scl_f, sda_f;
	logic       scl_p_q, sda_p_q;
	logic       rise, fall, start, stop;

	pin_sync #(
		.W         (2),
		.RESET_VAL (2'h3)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_ce      (i_ce),
		.i_pin     ({i_scl, i_sda}),
		.o_level   (pins_f)
	);

	assign scl_f = pins_f[1];
	assign sda_f = pins_f[0];
	assign rise  = scl_f && !scl_p_q;
	assign fall  = !scl_f && scl_p_q;
	assign start = scl_f && scl_p_q && sda_p_q && !sda_f;
	assign stop  = scl_f && scl_p_q && !sda_p_q && sda_f;

	// ==========================================================
	// Register state
	logic [1:0] sel_q, sel_d;
	logic [8:0] load_q, load_d;
	logic [1:0] down_q, down_d;
	logic       up_q, up_d;
	logic [1:0] ilim_q, ilim_d;
	logic       single_q, single_d;
	logic       double_q, double_d;
	logic       permit_q, permit_d;
	logic       meas_q, meas_d;
	logic       lock;
	reg_write_s wr_q, wr_d;
	logic       key_wr, other_wr;

	// ==========================================================
	// Serial target state
	i2c_state_e st_q, st_d;
	byte_kind_e kind_q, kind_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] ptr_q, ptr_d;
	logic       rw_q, rw_d;
	logic       ack_q, ack_d;
	logic       drive_q, drive_d;
	logic [7:0] rd_byte;

	// Returns the byte seen by a read at the given offset; unmapped offsets read zero.
	function automatic logic [7:0] read_reg(input logic [7:0] a);
		logic [7:0] r;
		r = `READ_ZERO;
		unique case (a)
			`OFS_MEAS_SELECT: r = {6'h00, sel_q};
			`OFS_LOAD_HIGH:   r = {7'h00, load_q[`POS_LOAD_MSB]};
			`OFS_LOAD_LOW:    r = load_q[7:0];
			`OFS_FREQ_CHOICE: r = {5'h00, up_q, down_q};
			`OFS_ILIM:        r = {6'h00, ilim_q};
			`OFS_OTP_STATUS:  r = {6'h00, double_q, single_q};
			`OFS_UNLOCK_KEY:  r = `READ_ZERO;
			`OFS_PIN_CTRL:    r = {6'h00, lock, permit_q};
			default:          r = `READ_ZERO;
		endcase
		return r;
	endfunction : read_reg

	assign rd_byte = read_reg(ptr_q);

	// ==========================================================
	// Serial target next state
	always_comb begin
		st_d    = st_q;
		kind_d  = kind_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		ptr_d   = ptr_q;
		rw_d    = rw_q;
		ack_d   = ack_q;
		drive_d = drive_q;
		wr_d    = '0;
		if (start) begin
			st_d    = I2C_RX;
			kind_d  = BYTE_ADDR;
			cnt_d   = `BIT_CNT_ZERO;
			drive_d = 1'b0;
		end else if (stop) begin
			st_d    = I2C_IDLE;
			drive_d = 1'b0;
		end else begin
			unique case (st_q)
				I2C_IDLE: st_d = I2C_IDLE;
				I2C_RX: begin
					if (rise && cnt_q != `BIT_CNT_FULL) begin
						sh_d  = {sh_q[6:0], sda_f};
						cnt_d = cnt_q + `BIT_CNT_ONE;
					end else if (fall && cnt_q == `BIT_CNT_FULL) begin
						drive_d = 1'b1;
						st_d    = I2C_ACK_OUT;
						unique case (kind_q)
							BYTE_ADDR: begin
								rw_d = sh_q[0];
								if (sh_q[7:1] != DEV_ADDR) begin
									drive_d = 1'b0;
									st_d    = I2C_IDLE;
								end
							end
							BYTE_REG: ptr_d = sh_q;
							default: begin
								wr_d.valid = 1'b1;
								wr_d.addr  = ptr_q;
								wr_d.data  = sh_q;
								ptr_d      = ptr_q + 8'h01;
							end
						endcase
					end
				end
				I2C_ACK_OUT: begin
					if (fall) begin
						cnt_d = `BIT_CNT_ZERO;
						if (kind_q == BYTE_ADDR && rw_q) begin
							sh_d    = rd_byte;
							ptr_d   = ptr_q + 8'h01;
							drive_d = !rd_byte[`POS_BIT_MSB];
							st_d    = I2C_TX;
						end else begin
							drive_d = 1'b0;
							kind_d  = (kind_q == BYTE_ADDR) ? BYTE_REG : BYTE_DATA;
							st_d    = I2C_RX;
						end
					end
				end
				I2C_TX: begin
					if (fall) begin
						if (cnt_q == `BIT_CNT_LAST) begin
							drive_d = 1'b0;
							st_d    = I2C_ACK_IN;
						end else begin
							sh_d    = {sh_q[6:0], 1'b0};
							cnt_d   = cnt_q + `BIT_CNT_ONE;
							drive_d = !sh_q[`POS_BIT_NEXT];
						end
					end
				end
				I2C_ACK_IN: begin
					if (rise) begin
						ack_d = !sda_f;
					end else if (fall) begin
						if (ack_q) begin
							sh_d    = rd_byte;
							ptr_d   = ptr_q + 8'h01;
							drive_d = !rd_byte[`POS_BIT_MSB];
							cnt_d   = `BIT_CNT_ZERO;
							st_d    = I2C_TX;
						end else begin
							st_d = I2C_IDLE;
						end
					end
				end
				default: st_d = I2C_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			st_q    <= I2C_IDLE;
			kind_q  <= BYTE_ADDR;
			cnt_q   <= `BIT_CNT_ZERO;
			sh_q    <= `REG_RESET;
			ptr_q   <= `REG_RESET;
			rw_q    <= 1'b0;
			ack_q   <= 1'b0;
			drive_q <= 1'b0;
			wr_q    <= '0;
		end else if (i_ce) begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
			st_q    <= st_d;
			kind_q  <= kind_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			ptr_q   <= ptr_d;
			rw_q    <= rw_d;
			ack_q   <= ack_d;
			drive_q <= drive_d;
			wr_q    <= wr_d;
		end
	end

	assign o_sda_o  = 1'b0;
	assign o_sda_oe = drive_q;

	// ==========================================================
	// Register bank next state
	assign key_wr   = wr_q.valid && wr_q.addr == `OFS_UNLOCK_KEY;
	assign other_wr = wr_q.valid && wr_q.addr != `OFS_UNLOCK_KEY;

	always_comb begin
		sel_d    = sel_q;
		down_d   = down_q;
		up_d     = up_q;
		ilim_d   = ilim_q;
		permit_d = permit_q;
		meas_d   = 1'b0;
		load_d   = i_load_valid ? i_load_current : load_q;
		single_d = i_otp_single_err;
		double_d = i_otp_double_err;
		if (i_otp_load) begin
			down_d   = i_otp_defaults.step_down_frequency_choice;
			up_d     = i_otp_defaults.step_up_frequency_choice;
			ilim_d   = i_otp_defaults.step_up_current_limit;
			permit_d = i_otp_defaults.pin_disable_permit;
		end
		if (wr_q.valid) begin
			unique case (wr_q.addr)
				`OFS_MEAS_SELECT: begin
					sel_d  = wr_q.data[1:0];
					meas_d = 1'b1;
				end
				`OFS_FREQ_CHOICE: down_d = wr_q.data[1:0];
				`OFS_ILIM:        ilim_d = wr_q.data[1:0];
				`OFS_PIN_CTRL: begin
					if (!wr_q.data[`POS_PERMIT] || (!i_watchdog_config_lock && !lock)) begin
						permit_d = wr_q.data[`POS_PERMIT];
					end
				end
				default: sel_d = sel_q;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			sel_q    <= 2'h0;
			load_q   <= 9'h000;
			down_q   <= 2'h0;
			up_q     <= 1'b0;
			ilim_q   <= 2'h0;
			single_q <= 1'b0;
			double_q <= 1'b0;
			permit_q <= 1'b0;
			meas_q   <= 1'b0;
		end else if (i_ce) begin
			sel_q    <= sel_d;
			load_q   <= load_d;
			down_q   <= down_d;
			up_q     <= up_d;
			ilim_q   <= ilim_d;
			single_q <= single_d;
			double_q <= double_d;
			permit_q <= permit_d;
			meas_q   <= meas_d;
		end
	end

	unlock_key_seq u_unlock (
		.i_ref_clk                 (i_ref_clk),
		.i_rst_n                   (i_rst_n),
		.i_ce                      (i_ce),
		.i_key_write               (key_wr),
		.i_key_data                (wr_q.data),
		.i_other_write             (other_wr),
		.i_watchdog_config_lock    (i_watchdog_config_lock),
		.i_watchdog_lock_write_one (i_watchdog_lock_write_one),
		.o_pin_disable_lock_status (lock)
	);

	// The converter index is the low select bit, so codes 0 and 2 share one converter.
	assign o_meas_start                 = meas_q;
	assign o_meas_sel                   = sel_q[0];
	assign o_step_down_frequency_choice = down_q;
	assign o_step_up_frequency_choice   = up_q;
	assign o_step_up_current_limit      = ilim_q;
	assign o_pin_disable_permit         = permit_q;
	assign o_pin_disable_lock_status    = lock;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence reg_write(logic [7:0] a);
		i_ce && wr_q.valid && wr_q.addr == a;
	endsequence

	sequence tx_first;
		i_ce && fall && !start && !stop && st_q == I2C_ACK_OUT && kind_q == BYTE_ADDR && rw_q;
	endsequence

	meas_start_a: assert property (
		reg_write(`OFS_MEAS_SELECT) |=> o_meas_start && o_meas_sel == $past(wr_q.data[0]))
		else $error("Measurement start or converter select wrong after select write.");

	load_capture_a: assert property (
		i_ce && i_load_valid |=> load_q == $past(i_load_current))
		else $error("Load-current count not captured.");

	load_low_read_a: assert property (
		tx_first ##0 (ptr_q == `OFS_LOAD_LOW) |=> sh_q == load_q[7:0])
		else $error("Low load-current byte not sent.");

	key_read_zero_a: assert property (
		tx_first ##0 (ptr_q == `OFS_UNLOCK_KEY) |=> sh_q == `READ_ZERO && drive_q)
		else $error("Key register read was not zero.");

	otp_flags_a: assert property (
		i_ce |=> double_q == $past(i_otp_double_err) && single_q == $past(i_otp_single_err))
		else $error("OTP correction flags do not follow their sources.");

	freq_write_a: assert property (
		reg_write(`OFS_FREQ_CHOICE) |=> o_step_down_frequency_choice == $past(wr_q.data[1:0]))
		else $error("Step-down frequency write not taken.");

	ilim_write_a: assert property (
		reg_write(`OFS_ILIM) |=> o_step_up_current_limit == $past(wr_q.data[1:0]))
		else $error("Step-up current limit write not taken.");

	step_up_otp_a: assert property (
		i_ce && i_otp_load |=> o_step_up_frequency_choice
			== $past(i_otp_defaults.step_up_frequency_choice))
		else $error("Step-up frequency not loaded from OTP.");

	permit_guard_a: assert property (
		i_ce && !permit_q && !i_otp_load |=> !permit_q
			|| $past(!i_watchdog_config_lock && !lock))
		else $error("Permit set while a lock was active.");
endmodule : pmic_status_config_regs

/* core/pmic_regs_defs.svh */
// Offsets, field positions, reset values and key codes of the status and configuration bank.
`ifndef PMIC_REGS_DEFS_SVH
`define PMIC_REGS_DEFS_SVH

// ==========================================================
// Register offsets
`define OFS_MEAS_SELECT  8'h2E
`define OFS_LOAD_HIGH    8'h2F
`define OFS_LOAD_LOW     8'h30
`define OFS_FREQ_CHOICE  8'h31
`define OFS_ILIM         8'h32
`define OFS_OTP_STATUS   8'h33
`define OFS_UNLOCK_KEY   8'h34
`define OFS_PIN_CTRL     8'h35

// ==========================================================
// Field positions and values
`define POS_PERMIT       0
`define POS_LOAD_MSB     8
`define POS_BIT_MSB      7
`define POS_BIT_NEXT     6
`define REG_RESET        8'h00
`define READ_ZERO        8'h00
`define LOCK_RESET       1'b1
`define LOAD_LSB_MA      20
`define LOAD_FULL_MA     10000

// ==========================================================
// Unlock key sequence
`define KEY_FIRST        8'h87
`define KEY_SECOND       8'h65
`define KEY_THIRD        8'h1B

// ==========================================================
// Serial byte counting
`define BIT_CNT_ZERO     4'h0
`define BIT_CNT_ONE      4'h1
`define BIT_CNT_LAST     4'h7
`define BIT_CNT_FULL     4'h8

`endif

/* core/pmic_regs_pkg.sv */
// Types shared by the status and configuration register bank.
package pmic_regs_pkg;

	typedef enum logic [2:0] {
		I2C_IDLE    = 3'h0,
		I2C_RX      = 3'h1,
		I2C_ACK_OUT = 3'h2,
		I2C_TX      = 3'h3,
		I2C_ACK_IN  = 3'h4
	} i2c_state_e;

	typedef enum logic [1:0] {
		BYTE_ADDR = 2'h0,
		BYTE_REG  = 2'h1,
		BYTE_DATA = 2'h2
	} byte_kind_e;

	typedef enum logic [1:0] {
		KEY_IDLE = 2'h0,
		KEY_GOT1 = 2'h1,
		KEY_GOT2 = 2'h2
	} key_state_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_s;

	typedef struct packed {
		logic [1:0] step_down_frequency_choice;
		logic       step_up_frequency_choice;
		logic [1:0] step_up_current_limit;
		logic       pin_disable_permit;
	} otp_defaults_s;

endpackage : pmic_regs_pkg

/* core/pin_sync.sv */
// Three-stage pin synchroniser whose output changes once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
	parameter int          W         = 2,
	parameter logic [W-1:0] RESET_VAL = '1
) (
	input  wire logic         i_ref_clk, // System clock.
	input  wire logic         i_rst_n,   // Synchronous reset, active low.
	input  wire logic         i_ce,      // Clock enable.
	input  wire logic [W-1:0] i_pin,     // Asynchronous pin levels.
	output logic      [W-1:0] o_level    // Filtered levels.
);
	logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic [W-1:0] lvl_d;

	always_comb begin
		for (int i = 0; i < W; i++) begin
			lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			s1_q  <= RESET_VAL;
			s2_q  <= RESET_VAL;
			s3_q  <= RESET_VAL;
			lvl_q <= RESET_VAL;
		end else if (i_ce) begin
			s1_q  <= i_pin;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign o_level = lvl_q;
endmodule : pin_sync

/* core/unlock_key_seq.sv */
// Key sequence checker that opens and closes the watchdog pin-disable lock.
`timescale 1ns/1ns
`include "pmic_regs_defs.svh"
module unlock_key_seq
	import pmic_regs_pkg::*;
(
	input  wire logic       i_ref_clk,                 // System clock.
	input  wire logic       i_rst_n,                   // Synchronous reset, active low.
	input  wire logic       i_ce,                      // Clock enable.
	input  wire logic       i_key_write,               // Write to the key register.
	input  wire logic [7:0] i_key_data,                // Value written to the key register.
	input  wire logic       i_other_write,             // Write to any other register.
	input  wire logic       i_watchdog_config_lock,    // Watchdog configuration lock level.
	input  wire logic       i_watchdog_lock_write_one, // Lock bit written to one.
	output logic            o_pin_disable_lock_status  // Lock status, from a register.
);
	key_state_e st_q, st_d;
	logic       lock_q, lock_d;

	// ==========================================================
	// Sequence tracking
	always_comb begin
		st_d   = st_q;
		lock_d = lock_q;
		if (i_key_write) begin
			lock_d = 1'b1;
			unique case (st_q)
				KEY_IDLE: st_d = (i_key_data == `KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
				KEY_GOT1: begin
					if (i_key_data == `KEY_SECOND) begin
						st_d = KEY_GOT2;
					end else begin
						st_d = (i_key_data == `KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
					end
				end
				KEY_GOT2: begin
					st_d = (i_key_data == `KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
					if (i_key_data == `KEY_THIRD && !i_watchdog_config_lock) begin
						lock_d = 1'b0;
					end
				end
				default: st_d = KEY_IDLE;
			endcase
		end else if (i_other_write) begin
			st_d = KEY_IDLE;
		end
		// Relocking wins over a sequence that completes in the same cycle.
		if (i_watchdog_lock_write_one) begin
			lock_d = 1'b1;
			st_d   = KEY_IDLE;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			st_q   <= KEY_IDLE;
			lock_q <= `LOCK_RESET;
		end else if (i_ce) begin
			st_q   <= st_d;
			lock_q <= lock_d;
		end
	end

	assign o_pin_disable_lock_status = lock_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence final_key;
		i_ce && i_key_write && st_q == KEY_GOT2 && i_key_data == `KEY_THIRD;
	endsequence

	unlock_open_a: assert property (
		final_key ##0 (!i_watchdog_config_lock && !i_watchdog_lock_write_one) |=> !lock_q)
		else $error("Lock did not open after a complete key sequence.");

	locked_hold_a: assert property (
		i_ce && i_watchdog_config_lock && lock_q |=> lock_q)
		else $error("Lock opened while the watchdog configuration lock was set.");

	relock_event_a: assert property (
		i_ce && (i_watchdog_lock_write_one || (i_key_write && !(st_q == KEY_GOT2
			&& i_key_data == `KEY_THIRD))) |=> lock_q)
		else $error("Lock not closed after a relocking event.");
endmodule : unlock_key_seq

/* tb/i2c_host_model.sv */
// Behavioural I2C controller that reaches the register bank from the host side.
`timescale 1ns/1ns
module i2c_host_model #(
	parameter logic [6:0] ADDR = 7'h60 // Target address; arbitrary value.
) (
	input  wire logic i_ref_clk, // System clock.
	input  wire logic i_sda,     // Resolved data wire.
	output logic      o_scl,     // Serial clock.
	output logic      o_sda_low  // Pulls data low when high.
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// ==========================================================
	// Bus phases
	// A quarter bit of seven clocks keeps both clock phases above the target's minimum.
	task automatic q;
		repeat (7) @(negedge i_ref_clk);
	endtask : q

	task automatic bit_io(input logic b, output logic r);
		o_sda_low = !b;
		q();
		o_scl = 1'b1;
		q();
		r = i_sda;
		q();
		o_scl = 1'b0;
		q();
	endtask : bit_io

	task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(last, nak);
	endtask : byte_io

	task automatic start;
		o_sda_low = 1'b0;
		q();
		o_scl = 1'b1;
		q();
		o_sda_low = 1'b1;
		q();
		o_scl = 1'b0;
		q();
	endtask : start

	task automatic stop;
		o_sda_low = 1'b1;
		q();
		o_scl = 1'b1;
		q();
		o_sda_low = 1'b0;
		q();
	endtask : stop

	// ==========================================================
	// Transactions
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       n0, n1, n2;
		start();
		byte_io({ADDR, 1'b0}, 1'b1, r, n0);
		byte_io(a, 1'b1, r, n1);
		byte_io(d, 1'b1, r, n2);
		stop();
		ok = ({n0, n1, n2} === 3'b000);
	endtask : wr

	// The last byte is answered with a not-acknowledge before the stop.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       n0, n1, n2, n3;
		start();
		byte_io({ADDR, 1'b0}, 1'b1, r, n0);
		byte_io(a, 1'b1, r, n1);
		start();
		byte_io({ADDR, 1'b1}, 1'b1, r, n2);
		byte_io(8'hFF, 1'b1, d, n3);
		stop();
		ok = ({n0, n1, n2} === 3'b000);
	endtask : rd
endmodule : i2c_host_model

/* tb/pmic_status_config_regs_tb.sv */
// Self-checking bench for the status and configuration register bank.
`timescale 1ns/1ns
module pmic_status_config_regs_tb
	import pmic_regs_pkg::*;
;
	logic          i_ref_clk, i_rst_n, scl, sda_low, sda_oe, sda_o, load_valid, otp_load, ce;
	logic          serr, derr, watchdog_config_lock, wd_one, meas_start, meas_sel, suf, permit, lock;
	logic [1:0]    sdf, ilim;
	logic [8:0]    load;
	logic [7:0]    got_v, exp_v;
	logic [7:0]    exp_q[$];
	otp_defaults_s otp_def;
	int            err_count, check_count, cyc, starts, s0, seed_v;
	event          res_ev;
	wire           sda = !(sda_low || (sda_oe && !sda_o));

	pmic_status_config_regs dut_u (
		.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_scl(scl), .i_sda(sda),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_load_current(load), .i_load_valid(load_valid),
		.i_otp_load(otp_load), .i_otp_defaults(otp_def), .i_otp_single_err(serr),
		.i_otp_double_err(derr), .i_watchdog_config_lock(watchdog_config_lock),
		.i_watchdog_lock_write_one(wd_one), .o_meas_start(meas_start), .o_meas_sel(meas_sel),
		.o_step_down_frequency_choice(sdf), .o_step_up_frequency_choice(suf),
		.o_step_up_current_limit(ilim), .o_pin_disable_permit(permit),
		.o_pin_disable_lock_status(lock)
	);
	i2c_host_model host_u (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

	// ==========================================================
	// Clock, cycle limit and result watcher
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end

	always @(posedge i_ref_clk) begin
		cyc++;
		if (meas_start === 1'b1) starts++;
		if (cyc == 80000) begin
			err_count++;
			$display("[ERR] %0t cycle limit reached", $time);
			print_verdict();
		end
	end

	initial forever begin
		@(res_ev);
		exp_v = exp_q.pop_front();
		check_count++;
		if (got_v !== exp_v) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got_v, exp_v);
		end
	end

	// ==========================================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		exp_q.push_back(exp);
		got_v = got;
		-> res_ev;
		@(negedge i_ref_clk);
	endtask : chk

	task automatic w(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		host_u.wr(a, d, ok);
		chk({7'h00, ok}, 8'h01);
	endtask : w

	task automatic r(input logic [7:0] a, input logic [7:0] exp);
		logic       ok;
		logic [7:0] d;
		host_u.rd(a, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask : r

	task automatic pulse(ref logic s);
		@(negedge i_ref_clk);
		s = 1'b1;
		@(negedge i_ref_clk);
		s = 1'b0;
		repeat (3) @(negedge i_ref_clk);
	endtask : pulse

	task automatic unlock;
		w(8'h34, 8'h87);
		w(8'h34, 8'h65);
		w(8'h34, 8'h1B);
	endtask : unlock

	task automatic print_verdict;
		if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Main sequence
	initial begin
		{i_rst_n, load_valid, otp_load, serr, derr, watchdog_config_lock, wd_one} = '0;
		ce = 1'b1;
		load = '0;
		otp_def = '0;
		seed_v = $urandom(32'hE55A7B46);
		repeat (16) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		repeat (6) @(negedge i_ref_clk);
		for (int a = 8'h2E; a < 8'h36; a++) r(8'(a), (a == 8'h35) ? 8'h02 : 8'h00);
		r(8'h10, 8'h00);
		for (int k = 0; k < 2; k++) begin
			load = 9'(k ? $urandom_range(500, 256) : $urandom_range(255, 0));
			pulse(load_valid);
			r(8'h2F, {7'h00, load[8]});
			r(8'h30, load[7:0]);
		end
		// A frozen bank must ignore a new count offered while the enable is low.
		ce = 1'b0;
		load = ~load;
		pulse(load_valid);
		ce = 1'b1;
		r(8'h30, ~load[7:0]);
		otp_def = otp_defaults_s'(6'($urandom()));
		pulse(otp_load);
		chk({2'b00, sdf, suf, ilim, permit}, {2'b00, otp_def});
		r(8'h35, {6'h00, 1'b1, otp_def.pin_disable_permit});
		s0 = starts;
		for (int c = 0; c < 4; c++) begin
			w(8'h31, 8'hFC | 8'(c));
			r(8'h31, {5'h00, otp_def.step_up_frequency_choice, 2'(c)});
			w(8'h32, 8'hFC | 8'(c));
			r(8'h32, {6'h00, 2'(c)});
			chk({4'h0, sdf, ilim}, {4'h0, 2'(c), 2'(c)});
			w(8'h2E, 8'(c));
			chk({7'h00, meas_sel}, {7'h00, 1'(c)});
		end
		chk(8'(starts - s0), 8'h04);
		for (int e = 0; e < 4; e++) begin
			{derr, serr} = 2'(e);
			r(8'h33, {6'h00, 2'(e)});
		end
		w(8'h35, 8'h00);
		w(8'h35, 8'h01);
		r(8'h35, 8'h02);
		unlock();
		r(8'h35, 8'h00);
		r(8'h34, 8'h00);
		watchdog_config_lock = 1'b1;
		w(8'h35, 8'h01);
		r(8'h35, 8'h00);
		watchdog_config_lock = 1'b0;
		w(8'h35, 8'h01);
		chk({6'h00, lock, permit}, 8'h01);
		w(8'h34, 8'h55);
		r(8'h35, 8'h03);
		unlock();
		pulse(wd_one);
		r(8'h35, 8'h03);
		w(8'h34, 8'h87);
		w(8'h34, 8'h65);
		w(8'h32, 8'h00);
		w(8'h34, 8'h1B);
		r(8'h35, 8'h03);
		watchdog_config_lock = 1'b1;
		unlock();
		r(8'h35, 8'h03);
		print_verdict();
	end
endmodule : pmic_status_config_regs_tb
